// ===== bit_sync.sv
// two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module bit_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // asynchronous in, synchronised out
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    typedef struct packed {
        logic [W-1:0] s2;
        logic [W-1:0] s1;
    } sync_state_type;

    sync_state_type st;
    sync_state_type nxt;

    // first stage feeds only the second stage
    always_comb begin
        nxt.s1 = din;
        nxt.s2 = st.s1;
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= nxt;
        end
    end

    assign dout = st.s2;

endmodule : bit_sync

`default_nettype wire

// ===== codec_model.sv
// behavioural stereo codec: bit clock master with 16-bit slots
`timescale 1ns/1ps
`default_nettype none

module codec_model #(
    parameter int HALF_NS = 40
) (
    // control from the bench
    input wire logic run,
    input wire logic [15:0] rx_pat,
    // pins
    input wire logic fs,
    input wire logic txd,
    output logic sck,
    output logic rxd,
    // observed traffic
    output logic [15:0] word,
    output logic word_tgl,
    output logic [7:0] fs_len,
    output logic [7:0] frame_len
);
    logic [3:0] pos = 4'h0;
    logic [15:0] sh = 16'h0000;
    logic go = 1'b0;
    logic live = 1'b0;
    logic [7:0] run_fs = 8'h00;
    logic [7:0] bits = 8'h00;
    logic rxd_q = 1'b0;
    logic [15:0] word_q = 16'h0000;
    logic tgl_q = 1'b0;
    logic [7:0] fs_max = 8'h00;
    logic [7:0] gap = 8'h00;

    // each output has a single source
    assign rxd = rxd_q;
    assign word = word_q;
    assign word_tgl = tgl_q;
    assign fs_len = fs_max;
    assign frame_len = gap;

    // bit clock runs only while the bench lets the codec master it
    initial begin
        sck = 1'b0;
        forever begin
            #HALF_NS;
            sck = run ? ~sck : 1'b0;
        end
    end

    // launch receive data msb first, first bit after the sync bit
    always @(posedge sck) begin
        pos = go ? 4'h0 : pos + 4'h1;
        live = live | go;
        rxd_q = live ? rx_pat[4'hf - pos] : ~rxd_q;
    end

    // sample sync and transmit data on the falling edge
    always @(negedge sck) begin
        if (live) begin
            sh = {sh[14:0], txd};
            if (pos == 4'hf) begin
                word_q = sh;
                // toggle late so the word has settled when it is seen
                tgl_q <= ~tgl_q;
            end
        end
        run_fs = fs ? run_fs + 8'h01 : 8'h00;
        if (run_fs > fs_max) fs_max = run_fs;
        bits = bits + 8'h01;
        if (fs) begin
            gap = bits;
            bits = 8'h00;
        end
        go = fs;
    end
endmodule : codec_model
`default_nettype wire

// ===== codec_port_pkg.sv
// constants, register map and state types of the codec serial port
package codec_port_pkg;

    // register offsets on the plain register port
    localparam logic [7:0] OFS_FORMAT = 8'h00;
    localparam logic [7:0] OFS_MODE = 8'h04;
    localparam logic [7:0] OFS_PFC_C = 8'h08;
    localparam logic [7:0] OFS_PFC_D = 8'h0C;
    localparam logic [7:0] OFS_TX_DATA = 8'h10;
    localparam logic [7:0] OFS_RX_DATA = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR = 8'h1C;
    localparam logic [7:0] OFS_ENABLE = 8'h20;

    // data word geometry
    localparam int WORD_W = 24;
    localparam int BUS_W = 32;
    localparam logic [23:0] REG_RESET = 24'h00_0000;

    // format control fields
    localparam int WL_HI = 21;
    localparam int WL_LO = 19;
    localparam int ALC_BIT = 18;
    localparam int DC_HI = 16;
    localparam int DC_LO = 12;
    localparam int PSR_BIT = 11;
    localparam int PM_HI = 7;
    localparam int PM_LO = 0;

    // word length codes and their bit counts
    localparam logic [2:0] WL_CODE_8 = 3'h0;
    localparam logic [2:0] WL_CODE_12 = 3'h1;
    localparam logic [2:0] WL_CODE_16 = 3'h2;
    localparam logic [4:0] WL_BITS_8 = 5'h08;
    localparam logic [4:0] WL_BITS_12 = 5'h0C;
    localparam logic [4:0] WL_BITS_16 = 5'h10;
    localparam logic [4:0] WL_BITS_24 = 5'h18;

    // mode control fields
    localparam int IE_HI = 23;
    localparam int IE_LO = 18;
    localparam int RE_BIT = 17;
    localparam int TE_BIT = 16;
    localparam int MOD_BIT = 13;
    localparam int SYN_BIT = 12;
    localparam int CKP_BIT = 11;
    localparam int FSP_BIT = 10;
    localparam int FSR_BIT = 9;
    localparam int FSL_HI = 8;
    localparam int FSL_LO = 7;
    localparam int SHIFT_DIRECTION_BIT_BIT = 6;
    localparam int CLOCK_DIRECTION_BIT_BIT = 5;
    localparam logic [1:0] FSL_WORD = 2'h0;

    // event bits, laid out like the interrupt enables in mode control
    localparam int EV_N = 6;
    localparam int EV_TX = 0;
    localparam int EV_RX = 1;
    localparam int EV_TXL = 2;
    localparam int EV_RXL = 3;
    localparam int EV_TXE = 4;
    localparam int EV_RXE = 5;

    // fixed pre-divider used while the prescaler range bit is clear
    localparam int PREDIV_DEF = 8;
    localparam int PRE_W = 3;

    // link sequencer, gray coded along idle, sync, run
    typedef enum logic [1:0] {
        LINK_IDLE = 2'b00,
        LINK_SYNC = 2'b01,
        LINK_RUN = 2'b11
    } link_state_type;

    // complete state of the port
    typedef struct packed {
        link_state_type link;
        logic [23:0] format;
        logic [23:0] mode;
        logic [23:0] pfc_c;
        logic [23:0] pfc_d;
        logic [23:0] tx_hold;
        logic [23:0] rx_hold;
        logic [23:0] tx_word;
        logic [23:0] rx_word;
        logic tx_full;
        logic rx_full;
        logic [PRE_W-1:0] pre_cnt;
        logic [7:0] div_cnt;
        logic sck_int;
        logic clk_prev;
        logic fs_on;
        logic [4:0] bit_cnt;
        logic [4:0] slot_cnt;
        logic [EV_N-1:0] status;
        logic [EV_N-1:0] enable;
        logic [BUS_W-1:0] rdata;
        logic irq;
        logic sck_out;
        logic sck_oe_n;
        logic fs_out;
        logic txd_out;
        logic txd_oe_n;
    } port_state_type;

endpackage : codec_port_pkg

// ===== codec_serial_port.sv
// synchronous serial audio port for a stereo codec, with register port
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module codec_serial_port #(
    parameter int PREDIV = codec_port_pkg::PREDIV_DEF
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // interrupt
    output logic irq,
    // bit clock pin
    input wire logic sck_in,
    output logic sck_out,
    output logic sck_oe_n,
    // frame sync and data pins
    output logic fs_out,
    output logic txd_out,
    output logic txd_oe_n,
    input wire logic rxd_in
);

    codec_port_pkg::port_state_type st;
    codec_port_pkg::port_state_type nxt;

    logic sck_sync;
    logic rxd_sync;
    logic active;
    logic [4:0] wl_n;
    logic [4:0] wl_last;
    logic [4:0] shamt;
    logic [4:0] last_slot;
    logic eff_clk;
    logic launch;
    logic sample;
    logic tick;
    logic run_en;
    logic rx_store;

    // pin inputs pass two flip-flops first
    bit_sync #(.W(2)) pin_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .din({sck_in, rxd_in}),
        .dout({sck_sync, rxd_sync})
    );

    // word length code to bit count
    function automatic logic [4:0] wl_bits(input logic [2:0] code);
        logic [4:0] n;
        n = codec_port_pkg::WL_BITS_24;
        case (code)
            codec_port_pkg::WL_CODE_8: n = codec_port_pkg::WL_BITS_8;
            codec_port_pkg::WL_CODE_12: n = codec_port_pkg::WL_BITS_12;
            codec_port_pkg::WL_CODE_16: n = codec_port_pkg::WL_BITS_16;
            default: n = codec_port_pkg::WL_BITS_24;
        endcase
        return n;
    endfunction : wl_bits

    // position in the 24-bit word of the n-th bit on the wire
    function automatic logic [4:0] bit_idx(input logic [4:0] n,
                                           input logic [4:0] sh,
                                           input logic lsb_first);
        logic [4:0] msb;
        msb = 5'(codec_port_pkg::WORD_W - 1);
        return lsb_first ? 5'(sh + n) : 5'(msb - n);
    endfunction : bit_idx

    // decoded configuration and bit clock edges
    assign active = (st.pfc_c != codec_port_pkg::REG_RESET);
    assign wl_n = wl_bits(st.format[codec_port_pkg::WL_HI:
                                    codec_port_pkg::WL_LO]);
    assign wl_last = 5'(wl_n - 5'h01);
    assign shamt = 5'(codec_port_pkg::WORD_W - wl_n);
    assign last_slot = st.mode[codec_port_pkg::MOD_BIT] ?
        st.format[codec_port_pkg::DC_HI:codec_port_pkg::DC_LO] :
        5'h00;
    assign eff_clk = st.mode[codec_port_pkg::CLOCK_DIRECTION_BIT_BIT] ?
        st.sck_int : sck_sync;
    assign launch = st.mode[codec_port_pkg::CKP_BIT] ?
        (~eff_clk & st.clk_prev) : (eff_clk & ~st.clk_prev);
    assign sample = st.mode[codec_port_pkg::CKP_BIT] ?
        (eff_clk & ~st.clk_prev) : (~eff_clk & st.clk_prev);
    assign tick = st.format[codec_port_pkg::PSR_BIT] ||
        (st.pre_cnt == codec_port_pkg::PRE_W'(PREDIV - 1));
    assign run_en = active && (st.mode[codec_port_pkg::TE_BIT] ||
                               st.mode[codec_port_pkg::RE_BIT]);
    assign rx_store = run_en && !launch && sample &&
        st.link == codec_port_pkg::LINK_RUN &&
        st.mode[codec_port_pkg::RE_BIT] && st.bit_cnt == wl_last;

    // next state of the whole port
    always_comb begin
        logic [codec_port_pkg::EV_N-1:0] ev;
        logic [codec_port_pkg::EV_N-1:0] clr;
        logic [4:0] nb;
        logic [4:0] ns;
        logic alignment_bit;
        logic sync_early_bit;
        logic te;
        logic first_bit;
        logic frame_end;
        logic [23:0] w;
        ev = '0;
        clr = '0;
        nb = st.bit_cnt;
        ns = st.slot_cnt;
        alignment_bit = st.format[codec_port_pkg::ALC_BIT];
        sync_early_bit = st.mode[codec_port_pkg::FSR_BIT];
        te = st.mode[codec_port_pkg::TE_BIT];
        first_bit = 1'b0;
        frame_end = 1'b0;
        w = st.tx_word;
        nxt = st;
        nxt.rdata = '0;
        nxt.clk_prev = eff_clk;

        // internal bit clock: pre-divider, then modulus plus one
        if (active && st.mode[codec_port_pkg::CLOCK_DIRECTION_BIT_BIT]) begin
            if (tick) begin
                nxt.pre_cnt = '0;
                if (st.div_cnt == st.format[codec_port_pkg::PM_HI:
                                            codec_port_pkg::PM_LO]) begin
                    nxt.div_cnt = '0;
                    nxt.sck_int = ~st.sck_int;
                end else begin
                    nxt.div_cnt = 8'(st.div_cnt + 8'h01);
                end
            end else begin
                nxt.pre_cnt = codec_port_pkg::PRE_W'(st.pre_cnt + 1'b1);
            end
        end else begin
            nxt.pre_cnt = '0;
            nxt.div_cnt = '0;
            nxt.sck_int = 1'b0;
        end

        // read side effects come before any store of a new word
        if (reg_rd) begin
            if (reg_addr == codec_port_pkg::OFS_FORMAT) begin
                nxt.rdata = {8'h00, st.format};
            end else if (reg_addr == codec_port_pkg::OFS_MODE) begin
                nxt.rdata = {8'h00, st.mode};
            end else if (reg_addr == codec_port_pkg::OFS_PFC_C) begin
                nxt.rdata = {8'h00, st.pfc_c};
            end else if (reg_addr == codec_port_pkg::OFS_PFC_D) begin
                nxt.rdata = {8'h00, st.pfc_d};
            end else if (reg_addr == codec_port_pkg::OFS_TX_DATA) begin
                nxt.rdata = {8'h00, st.tx_hold};
            end else if (reg_addr == codec_port_pkg::OFS_RX_DATA) begin
                nxt.rdata = {8'h00, st.rx_hold};
                nxt.rx_full = 1'b0;
            end else if (reg_addr == codec_port_pkg::OFS_STATUS) begin
                nxt.rdata = {26'h000_0000, st.status};
            end else if (reg_addr == codec_port_pkg::OFS_ENABLE) begin
                nxt.rdata = {26'h000_0000, st.enable};
            end else begin
                nxt.rdata = '0;
            end
        end

        // frame sequencer on the launch edge
        if (!run_en) begin
            nxt.link = codec_port_pkg::LINK_IDLE;
            nxt.bit_cnt = '0;
            nxt.slot_cnt = '0;
            nxt.fs_on = 1'b0;
            nxt.txd_out = 1'b0;
        end else if (launch) begin
            case (st.link)
                codec_port_pkg::LINK_IDLE: begin
                    nxt.link = sync_early_bit ? codec_port_pkg::LINK_SYNC :
                        codec_port_pkg::LINK_RUN;
                    nb = sync_early_bit ? wl_last : 5'h00;
                    ns = sync_early_bit ? last_slot : 5'h00;
                end
                default: begin
                    nxt.link = codec_port_pkg::LINK_RUN;
                    if (st.bit_cnt == wl_last) begin
                        nb = 5'h00;
                        ns = (st.slot_cnt == last_slot) ? 5'h00 :
                            5'(st.slot_cnt + 5'h01);
                    end else begin
                        nb = 5'(st.bit_cnt + 5'h01);
                    end
                end
            endcase
            nxt.bit_cnt = nb;
            nxt.slot_cnt = ns;
            first_bit = (nxt.link == codec_port_pkg::LINK_RUN) &&
                ns == 5'h00 && nb == 5'h00;
            frame_end = ns == last_slot && nb == wl_last;
            // word-long pulse in word mode, else one-bit pulse, either on or just before the first bit
            if (st.mode[codec_port_pkg::FSL_HI:codec_port_pkg::FSL_LO] ==
                codec_port_pkg::FSL_WORD) begin
                nxt.fs_on = sync_early_bit ? (frame_end || (ns == 5'h00 &&
                    nb != wl_last && nxt.link == codec_port_pkg::LINK_RUN))
                    : (ns == 5'h00);
            end else begin
                nxt.fs_on = sync_early_bit ? frame_end : first_bit;
            end
            // load the next transmit word at the start of each slot
            if (nxt.link == codec_port_pkg::LINK_RUN && nb == 5'h00 && te) begin
                w = alignment_bit ? (st.tx_hold << shamt) : st.tx_hold;
                nxt.tx_word = w;
                ev[codec_port_pkg::EV_TXE] = !st.tx_full;
                ev[codec_port_pkg::EV_TX] = 1'b1;
                ev[codec_port_pkg::EV_TXL] = (ns == last_slot);
                nxt.tx_full = 1'b0;
            end
            nxt.txd_out = (te && nxt.link == codec_port_pkg::LINK_RUN) ?
                w[bit_idx(nb, shamt, st.mode[codec_port_pkg::SHIFT_DIRECTION_BIT_BIT])] :
                1'b0;
        end else if (sample && st.link == codec_port_pkg::LINK_RUN &&
                     st.mode[codec_port_pkg::RE_BIT]) begin
            nxt.rx_word[bit_idx(st.bit_cnt, shamt,
                st.mode[codec_port_pkg::SHIFT_DIRECTION_BIT_BIT])] = rxd_sync;
            if (rx_store) begin
                nxt.rx_hold = alignment_bit ? (nxt.rx_word >> shamt) :
                    ((nxt.rx_word >> shamt) << shamt);
                ev[codec_port_pkg::EV_RXE] = st.rx_full;
                ev[codec_port_pkg::EV_RX] = 1'b1;
                ev[codec_port_pkg::EV_RXL] = (st.slot_cnt == last_slot);
                nxt.rx_full = 1'b1;
            end
        end

        // register writes; a transmit write wins over the load clear
        if (reg_wr) begin
            if (reg_addr == codec_port_pkg::OFS_FORMAT) begin
                nxt.format = reg_wdata[23:0];
            end else if (reg_addr == codec_port_pkg::OFS_MODE) begin
                nxt.mode = reg_wdata[23:0];
            end else if (reg_addr == codec_port_pkg::OFS_PFC_C) begin
                nxt.pfc_c = reg_wdata[23:0];
            end else if (reg_addr == codec_port_pkg::OFS_PFC_D) begin
                nxt.pfc_d = reg_wdata[23:0];
            end else if (reg_addr == codec_port_pkg::OFS_TX_DATA) begin
                nxt.tx_hold = reg_wdata[23:0];
                nxt.tx_full = 1'b1;
            end else if (reg_addr == codec_port_pkg::OFS_CLEAR) begin
                clr = reg_wdata[codec_port_pkg::EV_N-1:0];
            end else if (reg_addr == codec_port_pkg::OFS_ENABLE) begin
                nxt.enable = reg_wdata[codec_port_pkg::EV_N-1:0];
            end
        end

        // sticky status: a new event wins over a clear
        nxt.status = (st.status & ~clr) | ev;
        if (!active) begin
            nxt.status = '0;
            nxt.tx_full = 1'b0;
            nxt.rx_full = 1'b0;
        end

        // registered pin and interrupt outputs
        nxt.irq = |(nxt.status & nxt.enable &
            nxt.mode[codec_port_pkg::IE_HI:codec_port_pkg::IE_LO]);
        nxt.sck_out = nxt.sck_int;
        nxt.sck_oe_n = !(active && nxt.mode[codec_port_pkg::CLOCK_DIRECTION_BIT_BIT]);
        nxt.fs_out = nxt.fs_on ^ nxt.mode[codec_port_pkg::FSP_BIT];
        nxt.txd_oe_n = !(run_en && te);
    end

    // one register stage for the whole port
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
            st.sck_oe_n <= 1'b1;
            st.txd_oe_n <= 1'b1;
        end else begin
            st <= nxt;
        end
    end

    assign reg_rdata = st.rdata;
    assign irq = st.irq;
    assign sck_out = st.sck_out;
    assign sck_oe_n = st.sck_oe_n;
    assign fs_out = st.fs_out;
    assign txd_out = st.txd_out;
    assign txd_oe_n = st.txd_oe_n;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    sequence last_bit_launch;
        launch && run_en && st.link == codec_port_pkg::LINK_RUN &&
            st.bit_cnt == wl_last;
    endsequence

    port_reset_a: assert property (
        st.pfc_c == codec_port_pkg::REG_RESET |=>
            st.link == codec_port_pkg::LINK_IDLE && st.status == '0)
        else $error("port not held in reset by zero pin-function word");

    word16_wrap_a: assert property (
        (last_bit_launch and (wl_n == codec_port_pkg::WL_BITS_16) and
         (st.bit_cnt == 5'h0F)) |=> st.bit_cnt == 5'h00)
        else $error("16-bit word did not wrap after bit 15");

    left_justify_a: assert property (
        rx_store && !st.format[codec_port_pkg::ALC_BIT] &&
        wl_n == codec_port_pkg::WL_BITS_16 |=> st.rx_hold[7:0] == 8'h00)
        else $error("received sample not left-justified");

    slot_wrap_a: assert property (
        last_bit_launch and (st.slot_cnt == last_slot) |=>
            st.slot_cnt == 5'h00)
        else $error("frame did not end after slot count plus one");

    clock_div_a: assert property (
        active && st.mode[codec_port_pkg::CLOCK_DIRECTION_BIT_BIT] &&
        st.format[codec_port_pkg::PSR_BIT] && !reg_wr |=>
            (st.sck_int != $past(st.sck_int)) ==
            ($past(st.div_cnt) == $past(st.format[7:0])))
        else $error("internal bit clock toggled off the modulus");

    launch_edge_a: assert property (
        $past(active) && !st.mode[codec_port_pkg::CKP_BIT] &&
        $changed(st.txd_out) |-> $past(launch) && $past(eff_clk))
        else $error("transmit data changed away from a rising edge");

    early_sync_a: assert property (
        st.fs_on && st.link == codec_port_pkg::LINK_RUN &&
        st.mode[codec_port_pkg::FSR_BIT] &&
        st.mode[codec_port_pkg::FSL_HI:codec_port_pkg::FSL_LO] != 2'h0 |->
            st.bit_cnt == wl_last && st.slot_cnt == last_slot)
        else $error("early frame sync outside last bit of frame");

    sync_polarity_a: assert property (
        (!st.mode[codec_port_pkg::FSP_BIT] && !run_en && !reg_wr) [*2] |->
            !st.fs_out [*2])
        else $error("idle frame sync not low with positive polarity");

    clock_input_a: assert property (
        !st.mode[codec_port_pkg::CLOCK_DIRECTION_BIT_BIT] && !reg_wr |=> st.sck_oe_n)
        else $error("bit clock driven while set as input");

    irq_gate_a: assert property (
        active && (st.status & st.enable &
         st.mode[codec_port_pkg::IE_HI:codec_port_pkg::IE_LO]) != '0 &&
        !reg_wr |=> st.irq)
        else $error("enabled event did not raise the interrupt");

endmodule : codec_serial_port
`default_nettype wire

// ===== codec_serial_port_setup_tb.sv
// self-checking bench for the codec serial port against a codec model
`timescale 1ns/1ps
`default_nettype none

module codec_serial_port_setup_tb;
    logic sys_clk, rst, reg_wr, reg_rd, note, rd_d, irq, run, c_sck, rxd;
    logic sck_out, sck_oe_n, fs_out, txd_out, txd_oe_n, word_tgl;
    logic [7:0] reg_addr, fs_len, frame_len;
    logic [31:0] reg_wdata, reg_rdata, v;
    logic [15:0] rx_pat, w, word;
    logic [31:0] rd_q[$];
    logic [15:0] tx_q[$];
    int errors = 0;
    int checks_done = 0;
    int n, seed;

    codec_serial_port #(.PREDIV(2)) codec_serial_port_i (
        .sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .irq(irq),
        .sck_in(sck_oe_n ? c_sck : sck_out), .sck_out(sck_out),
        .sck_oe_n(sck_oe_n), .fs_out(fs_out), .txd_out(txd_out),
        .txd_oe_n(txd_oe_n), .rxd_in(rxd));

    codec_model codec_model_i (
        .run(run), .rx_pat(rx_pat), .fs(fs_out), .txd(txd_out),
        .sck(c_sck), .rxd(rxd), .word(word), .word_tgl(word_tgl),
        .fs_len(fs_len), .frame_len(frame_len));

    // system clock
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        if (errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        note <= 1'b1;
        rd_q.push_back(exp);
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        note <= 1'b0;
    endtask : rd

    task automatic get(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        @(negedge sys_clk);
        d = reg_rdata;
    endtask : get

    // read data stand only in the cycle after the read strobe
    always @(posedge sys_clk) rd_d <= reg_rd & note;
    always @(negedge sys_clk) if (rd_d) check(reg_rdata, rd_q.pop_front());

    // each word the codec captures against the oldest word written
    always @(word_tgl) if (tx_q.size() > 0)
        check({16'h0000, word}, {16'h0000, tx_q.pop_front()});

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        end_of_test();
    end

    // main sequence
    initial begin
        {rst, reg_wr, reg_rd, note, run} = 5'b10000;
        {reg_addr, reg_wdata, rx_pat} = '0;
        seed = $urandom(75027);
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        rd(codec_port_pkg::OFS_FORMAT, 32'h0000_0000);
        wr(8'h24, 32'h0000_ffff);
        rd(8'h24, 32'h0000_0000);
        wr(codec_port_pkg::OFS_PFC_C, 32'h0000_0000);
        wr(codec_port_pkg::OFS_PFC_D, 32'h0000_0000);
        wr(codec_port_pkg::OFS_FORMAT, 32'h0010_1807);
        wr(codec_port_pkg::OFS_MODE, 32'h00ff_330c);
        wr(codec_port_pkg::OFS_ENABLE, 32'h0000_003f);
        rd(codec_port_pkg::OFS_FORMAT, 32'h0010_1807);
        rd(codec_port_pkg::OFS_MODE, 32'h00ff_330c);
        rx_pat <= 16'($urandom);
        run <= 1'b1;
        repeat (200) @(posedge sys_clk);
        check({30'h0, fs_out, txd_oe_n}, 32'h0000_0001);
        wr(codec_port_pkg::OFS_PFC_C, 32'h0000_003e);
        w = 16'($urandom);
        wr(codec_port_pkg::OFS_TX_DATA, {8'h00, w, 8'h00});
        tx_q.push_back(w);
        for (int i = 0; i < 5; i++) begin
            n = 0;
            v = '0;
            while (v[codec_port_pkg::EV_TX] !== 1'b1 && n < 200) begin
                get(codec_port_pkg::OFS_STATUS, v);
                n++;
            end
            check({31'h0, v[codec_port_pkg::EV_TX]}, 32'h0000_0001);
            check({31'h0, irq}, 32'h0000_0001);
            wr(codec_port_pkg::OFS_CLEAR, v);
            if (v[codec_port_pkg::EV_RX] === 1'b1)
                rd(codec_port_pkg::OFS_RX_DATA, {8'h00, rx_pat, 8'h00});
            w = 16'($urandom);
            wr(codec_port_pkg::OFS_TX_DATA, {8'h00, w, 8'h00});
            tx_q.push_back(w);
        end
        check({24'h0, frame_len}, 32'h0000_0020);
        check({24'h0, fs_len}, 32'h0000_0001);
        check({30'h0, sck_oe_n, txd_oe_n}, 32'h0000_0002);
        wr(codec_port_pkg::OFS_ENABLE, 32'h0000_0000);
        repeat (2) @(posedge sys_clk);
        check({31'h0, irq}, 32'h0000_0000);
        n = 0;
        while (tx_q.size() > 0 && n < 600) begin
            @(posedge sys_clk);
            n++;
        end
        check(tx_q.size(), 32'h0000_0000);
        wr(codec_port_pkg::OFS_PFC_C, 32'h0000_0000);
        run <= 1'b0;
        repeat (3) @(posedge sys_clk);
        rd(codec_port_pkg::OFS_STATUS, 32'h0000_0000);
        wr(codec_port_pkg::OFS_MODE, 32'h00ff_332c);
        wr(codec_port_pkg::OFS_PFC_C, 32'h0000_003e);
        n = 0;
        while (sck_out !== 1'b1 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        while (sck_out !== 1'b0 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        n = 0;
        while (sck_out !== 1'b1 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        while (sck_out !== 1'b0 && n < 99) begin
            @(negedge sys_clk);
            n++;
        end
        check(n, 32'h0000_0010);
        check({31'h0, sck_oe_n}, 32'h0000_0000);
        end_of_test();
    end
endmodule : codec_serial_port_setup_tb
`default_nettype wire
